//--- logic/pipeline_hazard_stall_flush.sv
// Hazard detection, stall insertion and wrong-path flush for the core pipeline.
// Assumes decode presents one instruction descriptor per cycle and holds it while stalled.
// Notes on behaviour
// - Stall while two pipeline stages want the same resource in one cycle, until it clears.
// - A data access on the program memory bus stalls so the instruction fetch on that bus is serialized.
// - A read of a register or flag not yet updated by an earlier instruction stalls until the value is ready.
// - Early index-based addressing stalls when the previous instruction loads that index register.
// - Any change of flow flushes the old-flow instructions still in the pipeline.
// - 64-bit computes get stalls so dependants see the older generation's result latency.
// - A program memory bus data access with a conflict cache miss costs exactly one stall.
// - Two accesses to one memory block in one cycle, DMA included, cost one stall.
// - A conditional store followed by any load costs one stall.
// - A floating result forwarded to the very next dependent compute costs one stall.
// - Dual forwarding into the multiplier costs one stall from two back and two from one back.
// - A floating multiply feeding the next fixed ALU operation costs no stall.
// - Forwarding into or out of a 64-bit compute costs two stalls adjacent, one with one gap.
`timescale 1ns/1ps
module pipeline_hazard_stall_flush #(
  parameter int REG_W = hazard_pkg::REG_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // Instruction at decode
  input wire logic dec_valid_i,
  input wire logic [REG_W-1:0] dec_src_a_i,
  input wire logic [REG_W-1:0] dec_src_b_i,
  input wire logic dec_uses_flag_i,
  input wire logic dec_index_addr_i,
  input wire logic [REG_W-1:0] dec_index_reg_i,
  input wire logic dec_is_compute_i,
  input wire logic dec_is_fixed_alu_i,
  input wire logic dec_is_mult_i,
  input wire logic dec_is_64_i,
  input wire logic dec_is_load_i,
  input wire logic dec_is_cond_store_i,
  input wire logic dec_is_dual_i,
  input wire logic dec_is_float_i,
  input wire logic [REG_W-1:0] dec_dst_a_i,
  input wire logic [REG_W-1:0] dec_dst_b_i,
  input wire logic dec_sets_flag_i,
  input wire logic dec_loads_index_i,
  // Resource conflict reports from the memory system
  input wire logic pmb_data_access_i,
  input wire logic pmb_fetch_req_i,
  input wire logic pmb_conflict_miss_i,
  input wire logic block_collide_i,
  input wire logic resource_busy_i,
  input wire logic value_pending_i,
  // Change of flow
  input wire logic flow_change_i,
  // Pipeline control
  output logic hold_o,
  output logic bubble_o,
  output logic flush_o,
  output logic commit_en_o
);
  // Register addresses must stay narrow enough for the compare trees
  if (REG_W < 1 || REG_W > 8)
  begin : g_bad_reg_w
    $error("REG_W out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic v1;
    logic [REG_W-1:0] d1a;
    logic [REG_W-1:0] d1b;
    logic float1;
    logic mult1;
    logic dual1;
    logic c64_1;
    logic prod1;
    logic cstore1;
    logic flag1;
    logic ldidx1;
    logic v2;
    logic [REG_W-1:0] d2a;
    logic [REG_W-1:0] d2b;
    logic dual2;
    logic c64_2;
    logic prod2;
    logic hold;
    logic bubble;
    logic flush;
    logic commit;
  } haz_state_s;

  haz_state_s state_q;
  haz_state_s state_d;
  logic cnt_busy;
  logic cnt_load;
  logic [hazard_pkg::CNT_W-1:0] cnt_val;
  logic issue;
  logic dep1;
  logic dep2;
  logic dual_in1;
  logic dual_in2;
  logic struct_hit;
  logic [hazard_pkg::CNT_W-1:0] need;

  // Operand match against one older destination pair
  function automatic logic reads_dst(input logic [REG_W-1:0] a, input logic [REG_W-1:0] b,
                                     input logic [REG_W-1:0] x, input logic [REG_W-1:0] y);
    reads_dst = (a == x) || (a == y) || (b == x) || (b == y);
  endfunction

  // Larger of two stall counts
  function automatic logic [hazard_pkg::CNT_W-1:0] max2(input logic [hazard_pkg::CNT_W-1:0] a,
                                                         input logic [hazard_pkg::CNT_W-1:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  // ----------------------------------------
  // Hazard decode
  // ----------------------------------------
  always_comb
  begin
    dep1 = state_q.v1 && reads_dst(dec_src_a_i, dec_src_b_i, state_q.d1a, state_q.d1b);
    dep2 = state_q.v2 && reads_dst(dec_src_a_i, dec_src_b_i, state_q.d2a, state_q.d2b);
    dual_in1 = state_q.v1 && state_q.dual1 && dec_is_mult_i && dec_src_a_i == state_q.d1a
               && dec_src_b_i == state_q.d1b;
    dual_in2 = state_q.v2 && state_q.dual2 && dec_is_mult_i && dec_src_a_i == state_q.d2a
               && dec_src_b_i == state_q.d2b;
    // Level hazards hold for as long as their cause stands
    struct_hit = resource_busy_i
                 || (pmb_data_access_i && pmb_fetch_req_i)
                 || value_pending_i
                 || (dec_valid_i && dec_uses_flag_i && state_q.v1 && state_q.flag1)
                 || (dec_valid_i && dec_index_addr_i && state_q.v1 && state_q.ldidx1
                     && state_q.d1a == dec_index_reg_i);
    need = hazard_pkg::STALL_ZERO;
    if (pmb_conflict_miss_i)
      need = max2(need, hazard_pkg::STALL_ONE);
    if (block_collide_i)
      need = max2(need, hazard_pkg::STALL_ONE);
    if (dec_valid_i && dec_is_load_i && state_q.v1 && state_q.cstore1)
      need = max2(need, hazard_pkg::STALL_ONE);
    // Float multiply to fixed ALU is exempt
    if (dec_valid_i && dec_is_compute_i && dep1 && state_q.float1
        && !(state_q.mult1 && dec_is_fixed_alu_i))
      need = max2(need, hazard_pkg::STALL_ONE);
    if (dec_valid_i && dual_in2)
      need = max2(need, hazard_pkg::STALL_ONE);
    if (dec_valid_i && dual_in1)
      need = max2(need, hazard_pkg::STALL_TWO);
    // 64-bit on either end of the forward
    if (dec_valid_i && dep2 && state_q.prod2 && (dec_is_64_i || state_q.c64_2))
      need = max2(need, hazard_pkg::STALL_ONE);
    if (dec_valid_i && dep1 && state_q.prod1 && (dec_is_64_i || state_q.c64_1))
      need = max2(need, hazard_pkg::STALL_TWO);
    // A counted stall loads once, when the instruction first arrives; the load itself gives the
    // first stall cycle, so the counter only covers the rest and a flushed slot loads nothing
    cnt_load = need != hazard_pkg::STALL_ZERO && !cnt_busy && !struct_hit && !state_q.hold && !flow_change_i;
    cnt_val = need - hazard_pkg::STALL_ONE;
  end

  stall_counter #(
    .CNT_W(hazard_pkg::CNT_W)
  ) u_cnt (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .load_i(cnt_load),
    .count_i(cnt_val),
    .busy_o(cnt_busy)
  );

  // ----------------------------------------
  // Pipeline history and outputs
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    // Flush overrides stalls: the held instruction is wrong-path anyway
    state_d.flush = flow_change_i;
    state_d.hold = !flow_change_i && (struct_hit || cnt_load || (cnt_busy && state_q.hold));
    issue = dec_valid_i && !flow_change_i && !state_d.hold;
    state_d.bubble = !issue;
    // Flushed or bubble slots get no write enable
    state_d.commit = issue;
    state_d.v2 = state_q.v1 && !flow_change_i;
    state_d.d2a = state_q.d1a;
    state_d.d2b = state_q.d1b;
    state_d.dual2 = state_q.dual1;
    state_d.c64_2 = state_q.c64_1;
    state_d.prod2 = state_q.prod1;
    state_d.v1 = issue;
    state_d.d1a = dec_dst_a_i;
    state_d.d1b = dec_dst_b_i;
    state_d.float1 = dec_is_float_i && (dec_is_compute_i || dec_is_mult_i);
    state_d.mult1 = dec_is_mult_i;
    state_d.dual1 = dec_is_dual_i;
    state_d.c64_1 = dec_is_64_i;
    state_d.prod1 = dec_is_compute_i || dec_is_load_i || dec_is_64_i;
    state_d.cstore1 = dec_is_cond_store_i;
    state_d.flag1 = dec_sets_flag_i;
    state_d.ldidx1 = dec_loads_index_i;
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign hold_o = state_q.hold;
  assign bubble_o = state_q.bubble;
  assign flush_o = state_q.flush;
  assign commit_en_o = state_q.commit;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_flow;
    flow_change_i;
  endsequence

  // Counted stall loads of each length
  sequence s_load_one;
    cnt_load && need == hazard_pkg::STALL_ONE;
  endsequence

  sequence s_load_two;
    cnt_load && need == hazard_pkg::STALL_TWO;
  endsequence

  property p_flush;
    @(posedge clk_i) disable iff (!rstn_i) s_flow |=> flush_o && !commit_en_o;
  endproperty
  a_flush: assert property (p_flush) else $error("flow change not flushed");

  property p_pmb;
    @(posedge clk_i) disable iff (!rstn_i) (pmb_data_access_i && pmb_fetch_req_i && !flow_change_i) |=> hold_o;
  endproperty
  a_pmb: assert property (p_pmb) else $error("bus conflict not stalled");

  property p_busy;
    @(posedge clk_i) disable iff (!rstn_i) (resource_busy_i && !flow_change_i) |=> hold_o;
  endproperty
  a_busy: assert property (p_busy) else $error("resource conflict not stalled");

  property p_pend;
    @(posedge clk_i) disable iff (!rstn_i) (value_pending_i && !flow_change_i) |=> hold_o;
  endproperty
  a_pend: assert property (p_pend) else $error("pending value not stalled");

  property p_bubble;
    @(posedge clk_i) disable iff (!rstn_i) hold_o |-> bubble_o && !commit_en_o;
  endproperty
  a_bubble: assert property (p_bubble) else $error("hold without bubble");

  property p_one;
    @(posedge clk_i) disable iff (!rstn_i)
      s_load_one ##1 (!struct_hit && !flow_change_i) |-> (hold_o && !cnt_busy) ##1 !hold_o;
  endproperty
  a_one: assert property (p_one) else $error("single stall length wrong");

  property p_two;
    @(posedge clk_i) disable iff (!rstn_i)
      s_load_two ##1 !flow_change_i |-> (hold_o && cnt_busy) ##1 hold_o;
  endproperty
  a_two: assert property (p_two) else $error("double stall too short");

  property p_coll;
    @(posedge clk_i) disable iff (!rstn_i)
      (block_collide_i && !cnt_busy && !struct_hit && !state_q.hold && !flow_change_i) |=> hold_o;
  endproperty
  a_coll: assert property (p_coll) else $error("block collision not stalled");

  property p_commit;
    @(posedge clk_i) disable iff (!rstn_i) flush_o |-> !commit_en_o;
  endproperty
  a_commit: assert property (p_commit) else $error("flushed slot committed");
endmodule

//--- logic/hazard_pkg.sv
// Constants shared by the hazard interlock and its stall counter.
// Assumes a single core clock; no software-visible registers.
package hazard_pkg;
  // ----------------------------------------
  // Stall cycle figures
  // ----------------------------------------
  localparam logic [1:0] STALL_ONE = 2'h1;
  localparam logic [1:0] STALL_TWO = 2'h2;
  localparam logic [1:0] STALL_ZERO = 2'h0;
  // Register address width of the register file
  localparam int REG_W = 5;
  // Counter width for stall cycles
  localparam int CNT_W = 2;
endpackage

//--- logic/stall_counter.sv
// Down counter that holds the stall output for a loaded number of cycles.
// Assumes load is a single-cycle request from the interlock on the same clock.
`timescale 1ns/1ps
module stall_counter #(
  parameter int CNT_W = hazard_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic busy_o
);
  // The counter must reach the longest counted stall
  if (CNT_W < 2)
  begin : g_bad_cnt_w
    $error("CNT_W too small for the longest stall");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
  } cnt_state_s;

  cnt_state_s state_q;
  cnt_state_s state_d;

  // Next count: a fresh load beats the running decrement
  always_comb
  begin
    state_d = state_q;
    if (load_i && count_i != '0)
    begin
      state_d.cnt = count_i - CNT_W'(1);
      state_d.busy = 1'b1;
    end
    else if (state_q.cnt != '0)
    begin
      state_d.cnt = state_q.cnt - CNT_W'(1);
      state_d.busy = 1'b1;
    end
    else
    begin
      state_d.busy = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign busy_o = state_q.busy;
endmodule

//--- bench/tb.sv
// Self-checking bench for the pipeline hazard interlock: stall counts, bubbles and flush.
// Assumes one 40 MHz core clock and that decode re-presents an instruction while hold_o is high.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic dec_valid_i = 1'b0;
  logic [4:0] dec_src_a_i = 5'h00, dec_src_b_i = 5'h00, dec_index_reg_i = 5'h00;
  logic [4:0] dec_dst_a_i = 5'h00, dec_dst_b_i = 5'h00;
  logic [11:0] cls = 12'h000;
  logic pmb_data_access_i = 1'b0, pmb_fetch_req_i = 1'b0, pmb_conflict_miss_i = 1'b0;
  logic block_collide_i = 1'b0, resource_busy_i = 1'b0, value_pending_i = 1'b0, flow_change_i = 1'b0;
  logic hold_o, bubble_o, flush_o, commit_en_o;
  int errors = 0;
  int cmp_count = 0;
  pipeline_hazard_stall_flush DUT (.clk_i(clk_i), .rstn_i(rstn_i), .dec_valid_i(dec_valid_i),
    .dec_src_a_i(dec_src_a_i), .dec_src_b_i(dec_src_b_i), .dec_uses_flag_i(cls[11]),
    .dec_index_addr_i(cls[9]), .dec_index_reg_i(dec_index_reg_i), .dec_is_compute_i(cls[7]),
    .dec_is_fixed_alu_i(cls[6]), .dec_is_mult_i(cls[5]), .dec_is_64_i(cls[4]), .dec_is_load_i(cls[3]),
    .dec_is_cond_store_i(cls[2]), .dec_is_dual_i(cls[1]), .dec_is_float_i(cls[0]),
    .dec_dst_a_i(dec_dst_a_i), .dec_dst_b_i(dec_dst_b_i), .dec_sets_flag_i(cls[10]),
    .dec_loads_index_i(cls[8]), .pmb_data_access_i(pmb_data_access_i), .pmb_fetch_req_i(pmb_fetch_req_i),
    .pmb_conflict_miss_i(pmb_conflict_miss_i), .block_collide_i(block_collide_i),
    .resource_busy_i(resource_busy_i), .value_pending_i(value_pending_i), .flow_change_i(flow_change_i),
    .hold_o(hold_o), .bubble_o(bubble_o), .flush_o(flush_o), .commit_en_o(commit_en_o));

  // Free-running core clock, 25 ns period
  always #12.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Class bits: flag use, flag set, index addr, index load, compute, fixed, mult, 64, load, cstore, dual, float
  task automatic put(input logic v, input logic [11:0] c, input logic [4:0] sa, input logic [4:0] da);
    @(posedge clk_i);
    dec_valid_i <= v;
    cls <= c;
    dec_src_a_i <= sa;
    dec_src_b_i <= sa + 5'h01;
    dec_index_reg_i <= sa;
    dec_dst_a_i <= da;
    dec_dst_b_i <= da + 5'h01;
  endtask

  // Count registered hold cycles while the consumer waits; each must carry a bubble and no commit
  task automatic count_hold(output int n);
    logic h;
    n = 0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk_i);
      h = hold_o;
      if (h === 1'b1)
      begin
        n++;
        chk({bubble_o, commit_en_o}, 4'h2);
      end
      if (h !== 1'b1)
      begin
        // The held instruction issues on the cycle the hold drops
        chk({bubble_o, commit_en_o}, 4'h1);
        break;
      end
    end
    put(1'b0, 12'h000, 5'h00, 5'h1E);
    repeat (3) @(posedge clk_i);
  endtask

  // Producer, optional unrelated instruction, then a consumer reading the producer's destinations
  task automatic dep(input logic [11:0] pc, input logic [11:0] cc, input logic gap, output int n);
    put(1'b1, pc, 5'h10, 5'h01);
    if (gap)
      put(1'b1, 12'h080, 5'h12, 5'h14);
    put(1'b1, cc, 5'h01, 5'h18);
    count_hold(n);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_compute();
    int n;
    dep(12'h081, 12'h081, 1'b0, n);
    chk(n[3:0], 4'h1);
    dep(12'h083, 12'h0A1, 1'b0, n);
    chk(n[3:0], 4'h2);
    dep(12'h083, 12'h0A1, 1'b1, n);
    chk(n[3:0], 4'h1);
    dep(12'h0A1, 12'h0C0, 1'b0, n);
    chk(n[3:0], 4'h0);
    dep(12'h008, 12'h090, 1'b0, n);
    chk(n[3:0], 4'h2);
    dep(12'h080, 12'h090, 1'b1, n);
    chk(n[3:0], 4'h1);
  endtask

  task automatic t_memory();
    int n;
    dep(12'h004, 12'h008, 1'b0, n);
    chk(n[3:0], 4'h1);
    dep(12'h480, 12'h880, 1'b0, n);
    chk(n[3:0], 4'h1);
    dep(12'h108, 12'h200, 1'b0, n);
    chk({3'h0, n > 0}, 4'h1);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      pmb_conflict_miss_i <= (k == 0);
      block_collide_i <= (k == 1);
      @(posedge clk_i);
      pmb_conflict_miss_i <= 1'b0;
      block_collide_i <= 1'b0;
      n = 0;
      repeat (5)
      begin
        @(negedge clk_i);
        n += int'(hold_o === 1'b1);
      end
      chk(n[3:0], 4'h1);
    end
  endtask

  // Level causes keep the hold up while they stand and release it within a few cycles after
  task automatic t_levels();
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_i);
      resource_busy_i <= (k == 0);
      value_pending_i <= (k == 1);
      pmb_data_access_i <= (k == 2);
      pmb_fetch_req_i <= (k == 2);
      repeat (3)
      begin
        @(posedge clk_i);
        @(negedge clk_i);
        chk({3'h0, hold_o}, 4'h1);
      end
      @(posedge clk_i);
      {resource_busy_i, value_pending_i, pmb_data_access_i, pmb_fetch_req_i} <= 4'h0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk({3'h0, hold_o}, 4'h0);
    end
  endtask

  // Change of flow while an instruction that needs a counted stall is presented, so the stall counter never loads
  task automatic t_flush();
    put(1'b1, 12'h081, 5'h10, 5'h01);
    put(1'b1, 12'h081, 5'h01, 5'h18);
    flow_change_i <= 1'b1;
    @(posedge clk_i);
    flow_change_i <= 1'b0;
    @(negedge clk_i);
    chk({flush_o, commit_en_o}, 4'h2);
    @(negedge clk_i);
    chk({flush_o, commit_en_o}, 4'h1);
    put(1'b0, 12'h000, 5'h00, 5'h1E);
    repeat (4) @(posedge clk_i);
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs well under 400 cycles; the limit leaves generous margin
  initial
  begin
    #(3000 * 25);
    errors++;
    end_of_test();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    chk({hold_o, bubble_o, flush_o, commit_en_o}, 4'h0);
    t_compute();
    t_memory();
    t_levels();
    t_flush();
    end_of_test();
  end
endmodule
